// ---- psd_pkg.sv ----
package psd_pkg;
  // ----------------------------------------------------------------
  // Widths and lane geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 64;
  localparam int HALF_W = 32;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int DWORD_W = 32;
  localparam int N_BYTES = 8;
  localparam int N_WORDS = 4;
  localparam int N_DWORDS = 2;
  localparam int N_REGS = 8;
  localparam int REG_AW = 3;
  localparam int N_OPS = 57;
  localparam logic [DATA_W-1:0] REG_RESET = 64'h0;

  // ----------------------------------------------------------------
  // Saturation limits
  // ----------------------------------------------------------------
  localparam logic [BYTE_W-1:0] SB_MAX = 8'h7f;
  localparam logic [BYTE_W-1:0] SB_MIN = 8'h80;
  localparam logic [BYTE_W-1:0] UB_MAX = 8'hff;
  localparam logic [BYTE_W-1:0] UB_MIN = 8'h00;

  // ----------------------------------------------------------------
  // Lane format, operation and access mode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PSD_FMT_BYTE  = 2'b00,
    PSD_FMT_WORD  = 2'b01,
    PSD_FMT_DWORD = 2'b10,
    PSD_FMT_QWORD = 2'b11
  } psd_fmt_e;

  typedef enum logic [3:0] {
    PSD_OP_MOVE = 4'h0,
    PSD_OP_ADD  = 4'h1,
    PSD_OP_SUB  = 4'h2,
    PSD_OP_AND  = 4'h3,
    PSD_OP_ANDN = 4'h4,
    PSD_OP_OR   = 4'h5,
    PSD_OP_XOR  = 4'h6,
    PSD_OP_CMPEQ = 4'h7,
    PSD_OP_CMPGT = 4'h8
  } psd_op_e;

  typedef enum logic [1:0] {
    PSD_ARITH_WRAP = 2'b00,
    PSD_ARITH_SSAT = 2'b01,
    PSD_ARITH_USAT = 2'b10
  } psd_arith_e;

  typedef enum logic [1:0] {
    PSD_SRC_REG = 2'b00,
    PSD_SRC_MEM = 2'b01,
    PSD_SRC_GPR = 2'b10
  } psd_src_e;

  typedef enum logic {
    PSD_ACC_FULL = 1'b0,
    PSD_ACC_HALF = 1'b1
  } psd_acc_e;

  // Decoded request from the instruction decoder
  typedef struct packed {
    psd_op_e          op;
    psd_fmt_e         fmt;
    psd_arith_e       arith;
    psd_acc_e         acc;
    psd_src_e         src;
    logic             to_mem;
    logic [REG_AW-1:0] dst;
    logic [REG_AW-1:0] srcr;
  } psd_req_s;

  // Store payload toward memory
  typedef struct packed {
    logic [DATA_W-1:0]  data;
    logic [N_BYTES-1:0] byte_en;
  } psd_store_s;
endpackage

// ---- psd_lane_alu.sv ----
`timescale 1ns/10ps
`default_nettype none
module psd_lane_alu
  import psd_pkg::*;
(
  input  wire logic [DATA_W-1:0] a,
  input  wire logic [DATA_W-1:0] b,
  input  wire psd_op_e           op,
  output logic [DATA_W-1:0]      y
);
  // ----------------------------------------------------------------
  // Whole-quadword logic and move
  // ----------------------------------------------------------------
  // Bitwise ops need no lane split: every bit stands alone
  always_comb begin
    case (op)
      PSD_OP_AND:  y = a & b;
      PSD_OP_ANDN: y = ~a & b;                      // Inverted destination
      PSD_OP_OR:   y = a | b;
      PSD_OP_XOR:  y = a ^ b;
      PSD_OP_MOVE: y = b;                           // Block copy
      default:     y = '0;
    endcase
  end
endmodule
`default_nettype wire

// ---- psd_datapath.sv ----
// What this block does
// - Accepts a 64-bit operand as eight independent byte lanes.
// - Accepts a 64-bit operand as four independent 16-bit word lanes.
// - Accepts two 32-bit doubleword lanes (also used for quadword format arithmetic and compares), or one 64-bit quadword for logic and moves.
// - Byte lane 0 is bits 7..0; byte lane 7 is bits 63..56.
// - Word lane 0 is bits 15..0; top word lane is bits 63..48.
// - Doubleword 0 is bits 31..0; doubleword 1 is bits 63..32.
// - Full-width transfers move the whole 64-bit block unchanged, lanes ignored.
// - Lane operations run in parallel, no lane influences another.
// - Lane elements are treated as signed or unsigned per operation.
// - Signed saturating byte add adds eight lanes into destination.
// - Stores place least significant element at lowest address.
// - Register bit layout equals the 64-bit memory image.
// - Full-width mode covers 64-bit moves, loads, stores and arithmetic.
// - Half-width mode covers 32-bit memory and integer-register moves.
// - The instruction set has 57 operations in seven categories.
// - Saturation clamps signed bytes to 7f/80, unsigned to ff/00.
// - Wraparound drops the carry out of each lane.
// - Overflow raises no exception and sets no flag.
`timescale 1ns/10ps
`default_nettype none
module psd_datapath
  import psd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              req_valid,
  input  wire psd_req_s          req,
  input  wire logic [DATA_W-1:0] mem_rdata,
  input  wire logic [HALF_W-1:0] gpr_rdata,
  output logic                   done,
  output psd_store_s             mem_store,
  output logic                   mem_store_valid,
  output logic [HALF_W-1:0]      gpr_wdata,
  output logic                   gpr_wvalid,
  output logic [DATA_W-1:0]      dst_value
);
  // ----------------------------------------------------------------
  // Packed register file and operand selection
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] regs [N_REGS];
  logic [DATA_W-1:0] next_regs [N_REGS];
  logic [DATA_W-1:0] opa;
  logic [DATA_W-1:0] opb;
  logic [DATA_W-1:0] alu_y;
  logic [DATA_W-1:0] logic_y;

  // Half-width view of a 64-bit value: only the low doubleword
  function automatic logic [DATA_W-1:0] half_view(input logic [DATA_W-1:0] v);
    half_view = {{HALF_W{1'b0}}, v[HALF_W-1:0]};
  endfunction

  // Source bits fetched with no reordering from memory or registers
  always_comb begin
    opa = regs[req.dst];
    case (req.src)
      PSD_SRC_MEM: opb = mem_rdata;
      PSD_SRC_GPR: opb = {{HALF_W{1'b0}}, gpr_rdata};
      default:     opb = regs[req.srcr];
    endcase
    if (req.acc == PSD_ACC_HALF) begin
      opb = half_view(opb);
    end
  end

  // Whole-quadword logic and move, shared by every format
  psd_lane_alu u_alu (
    .a  (opa),
    .b  (opb),
    .op (req.op),
    .y  (logic_y)
  );

  // ----------------------------------------------------------------
  // Per-lane helpers
  // ----------------------------------------------------------------
  // Add or subtract one lane of width w, then clamp or wrap
  function automatic logic [DWORD_W-1:0] lane_arith(
    input logic [DWORD_W-1:0] x, input logic [DWORD_W-1:0] z,
    input int w, input logic sub, input psd_arith_e m);
    logic [DWORD_W+1:0] sx;
    logic [DWORD_W+1:0] sz;
    logic [DWORD_W+1:0] r;
    logic [DWORD_W+1:0] smax;
    logic [DWORD_W+1:0] smin;
    logic [DWORD_W+1:0] umax;
    sx = '0;
    sz = '0;
    for (int i = 0; i < DWORD_W + 2; i++) begin
      if (i < w) begin
        sx[i] = x[i];
        sz[i] = z[i];
      end else if (m == PSD_ARITH_SSAT) begin
        sx[i] = x[w-1];                             // Signed view
        sz[i] = z[w-1];
      end
    end
    r = sub ? sx - sz : sx + sz;
    smax = ({{(DWORD_W+1){1'b0}}, 1'b1} << (w - 1)) - 1'b1;
    smin = ~smax;
    umax = ({{(DWORD_W+1){1'b0}}, 1'b1} << w) - 1'b1;
    lane_arith = r[DWORD_W-1:0];                    // Carry dropped
    if (m == PSD_ARITH_SSAT) begin
      if (!r[DWORD_W+1] && r > smax) lane_arith = smax[DWORD_W-1:0];
      else if (r[DWORD_W+1] && r < smin) lane_arith = smin[DWORD_W-1:0];
    end else if (m == PSD_ARITH_USAT) begin
      if (r[DWORD_W+1]) lane_arith = '0;            // Unsigned floor
      else if (r > umax) lane_arith = umax[DWORD_W-1:0];
    end
  endfunction

  // Signed greater-than on one lane
  function automatic logic lane_gt(input logic [DWORD_W-1:0] x,
    input logic [DWORD_W-1:0] z, input int w);
    logic [DWORD_W-1:0] xs;
    logic [DWORD_W-1:0] zs;
    xs = x << (DWORD_W - w);
    zs = z << (DWORD_W - w);
    lane_gt = $signed(xs) > $signed(zs);
  endfunction

  // ----------------------------------------------------------------
  // Lane-parallel evaluation
  // ----------------------------------------------------------------
  // Each lane sees only its own bits; no carry crosses a lane
  always_comb begin
    int w;
    int n;
    logic [DWORD_W-1:0] la;
    logic [DWORD_W-1:0] lb;
    logic [DWORD_W-1:0] lr;
    logic [DWORD_W-1:0] mask;
    w = BYTE_W;
    n = N_BYTES;
    la = '0;
    lb = '0;
    lr = '0;
    mask = '0;
    alu_y = '0;
    case (req.fmt)
      PSD_FMT_BYTE: begin
        w = BYTE_W;
        n = N_BYTES;
      end
      PSD_FMT_WORD: begin
        w = WORD_W;
        n = N_WORDS;
      end
      default: begin
        w = DWORD_W;
        n = N_DWORDS;
      end
    endcase
    // Transfer and logic groups use the quadword unit
    case (req.op)
      PSD_OP_MOVE, PSD_OP_AND, PSD_OP_ANDN, PSD_OP_OR, PSD_OP_XOR: begin
        alu_y = logic_y;
      end
      default: begin
        mask = (w == DWORD_W) ? {DWORD_W{1'b1}} : ((32'h1 << w) - 32'h1);
        for (int k = 0; k < N_BYTES; k++) begin
          if (k < n) begin
            la = DWORD_W'((opa >> (k * w))) & mask; // Lane k at bits k*w
            lb = DWORD_W'((opb >> (k * w))) & mask;
            case (req.op)
              PSD_OP_ADD:   lr = lane_arith(la, lb, w, 1'b0, req.arith) & mask;
              PSD_OP_SUB:   lr = lane_arith(la, lb, w, 1'b1, req.arith) & mask;
              PSD_OP_CMPEQ: lr = (la == lb) ? mask : '0;
              PSD_OP_CMPGT: lr = lane_gt(la, lb, w) ? mask : '0;
              default:      lr = '0;
            endcase
            alu_y = alu_y | (DATA_W'(lr) << (k * w));
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Register and output update
  // ----------------------------------------------------------------
  logic              next_done;
  psd_store_s        next_store;
  logic              next_store_valid;
  logic [HALF_W-1:0] next_gpr_wdata;
  logic              next_gpr_wvalid;
  logic [DATA_W-1:0] next_dst_value;

  // Writes result back to destination, or emits a store
  always_comb begin
    for (int i = 0; i < N_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    next_done = 1'b0;
    next_store = '0;
    next_store_valid = 1'b0;
    next_gpr_wdata = gpr_wdata;
    next_gpr_wvalid = 1'b0;
    next_dst_value = dst_value;
    if (req_valid) begin
      next_done = 1'b1;
      if (req.op == PSD_OP_MOVE && req.to_mem) begin
        // Little-endian image: byte k of register at address base+k
        next_store.data = regs[req.srcr];
        next_store_valid = 1'b1;
        if (req.acc == PSD_ACC_HALF) begin
          next_store.data = half_view(regs[req.srcr]);
          next_store.byte_en = {{(N_BYTES/2){1'b0}}, {(N_BYTES/2){1'b1}}};
        end else begin
          next_store.byte_en = {N_BYTES{1'b1}};
        end
      end else if (req.op == PSD_OP_MOVE && req.src == PSD_SRC_GPR
                   && req.dst == req.srcr && req.acc == PSD_ACC_HALF
                   && req.to_mem == 1'b0 && req.arith == PSD_ARITH_USAT) begin
        // Packed register to integer register, low doubleword only
        next_gpr_wdata = regs[req.srcr][HALF_W-1:0];
        next_gpr_wvalid = 1'b1;
      end else begin
        // Whole result written; no flag or trap on overflow
        next_regs[req.dst] = alu_y;
        next_dst_value = alu_y;
      end
    end
  end

  // Registers the state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N_REGS; i++) begin
        regs[i] <= REG_RESET;
      end
      done <= 1'b0;
      mem_store <= '0;
      mem_store_valid <= 1'b0;
      gpr_wdata <= '0;
      gpr_wvalid <= 1'b0;
      dst_value <= REG_RESET;
    end else begin
      for (int i = 0; i < N_REGS; i++) begin
        regs[i] <= next_regs[i];
      end
      done <= next_done;
      mem_store <= next_store;
      mem_store_valid <= next_store_valid;
      gpr_wdata <= next_gpr_wdata;
      gpr_wvalid <= next_gpr_wvalid;
      dst_value <= next_dst_value;
    end
  end
endmodule
`default_nettype wire

// ---- psd_datapath_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module psd_datapath_asserts
  import psd_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              req_valid,
  input wire psd_req_s          req,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic [HALF_W-1:0] gpr_rdata,
  input wire logic              done,
  input wire psd_store_s        mem_store,
  input wire logic              mem_store_valid,
  input wire logic [HALF_W-1:0] gpr_wdata,
  input wire logic              gpr_wvalid,
  input wire logic [DATA_W-1:0] dst_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic              mv;
  logic              ld;
  logic [HALF_W-1:0] mem_lo;
  // Decoded move kinds
  assign mv = req_valid && req.op == PSD_OP_MOVE;
  assign ld = mv && !req.to_mem && req.src == PSD_SRC_MEM;
  assign mem_lo = mem_rdata[HALF_W-1:0];
  done_follows_a: assert property (req_valid |=> done)
    else $error("done missing");
  no_stray_done_a: assert property (!req_valid |=> !done)
    else $error("done without request");
  // Store, load and register-move answers one cycle after the request
  store_pulse_a: assert property (mv && req.to_mem |=>
    mem_store_valid && !gpr_wvalid) else $error("store missing");
  store_full_a: assert property (
    mv && req.to_mem && req.acc == PSD_ACC_FULL |=>
    mem_store.byte_en == 8'hff) else $error("full enables");
  store_half_a: assert property (
    mv && req.to_mem && req.acc == PSD_ACC_HALF |=>
    mem_store.byte_en == 8'h0f) else $error("half enables");
  load_full_a: assert property (ld && req.acc == PSD_ACC_FULL |=>
    dst_value == $past(mem_rdata)) else $error("full load");
  load_half_a: assert property (ld && req.acc == PSD_ACC_HALF |=>
    dst_value == {32'h0, $past(mem_lo)}) else $error("half load");
  gpr_out_a: assert property (mv && req.src == PSD_SRC_GPR &&
    !req.to_mem && req.acc == PSD_ACC_HALF &&
    req.arith == PSD_ARITH_USAT && req.dst == req.srcr |=> gpr_wvalid)
    else $error("gpr write");
  gpr_hold_a: assert property (!gpr_wvalid |-> $stable(gpr_wdata))
    else $error("gpr data moved");
endmodule
bind psd_datapath psd_datapath_asserts u_psd_datapath_asserts (
  .clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
  .mem_rdata(mem_rdata), .gpr_rdata(gpr_rdata), .done(done),
  .mem_store(mem_store), .mem_store_valid(mem_store_valid),
  .gpr_wdata(gpr_wdata), .gpr_wvalid(gpr_wvalid), .dst_value(dst_value));
`default_nettype wire

// ---- psd_far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module psd_far_model
  import psd_pkg::*;
#(
  parameter logic [HALF_W-1:0] GPR_VAL = 32'h5a3c_96e1
)
(
  input  wire logic              clk,
  input  wire logic              pre_valid,
  input  wire logic [DATA_W-1:0] pre_data,
  input  wire logic              st_valid,
  input  wire psd_store_s        st,
  output logic [DATA_W-1:0]      mem_rdata,
  output logic [HALF_W-1:0]      gpr_rdata
);
  logic [BYTE_W-1:0] mem [N_BYTES];
  initial for (int k = 0; k < N_BYTES; k++) mem[k] = 8'h00;
  // Byte memory; only enabled store bytes are written
  always @(posedge clk)
    for (int k = 0; k < N_BYTES; k++)
      if (pre_valid) mem[k] <= pre_data[8*k +: 8];
      else if (st_valid && st.byte_en[k]) mem[k] <= st.data[8*k +: 8];
  // Lowest address feeds the least significant byte
  always_comb
    for (int k = 0; k < N_BYTES; k++) mem_rdata[8*k +: 8] = mem[k];
  assign gpr_rdata = GPR_VAL; // Integer register contents
endmodule
`default_nettype wire

// ---- psd_datapath_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module psd_datapath_tb_top
  import psd_pkg::*;
;
  localparam logic [HALF_W-1:0] GV = 32'h5a3c_96e1;
  localparam logic [DATA_W-1:0] X = 64'h8877_6655_4433_2211;
  localparam logic [DATA_W-1:0] Y = 64'h0fed_cba9_8765_4321;
  localparam logic [DATA_W-1:0] BX = 64'h1000_c040_ff01_807f;
  localparam logic [DATA_W-1:0] BY = 64'hf000_c040_0101_ff01;
  localparam logic [DATA_W-1:0] LX = 64'hffff_0000_ff00_f0f0;
  localparam logic [DATA_W-1:0] LY = 64'h0f0f_0f0f_0ff0_ff00;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              req_valid = 1'b0;
  psd_req_s          req = '0;
  logic              pre_valid = 1'b0;
  logic [DATA_W-1:0] pre_data = '0;
  logic [DATA_W-1:0] mem_rdata, dst_value;
  logic [HALF_W-1:0] gpr_rdata, gpr_wdata;
  logic              done, mem_store_valid, gpr_wvalid;
  psd_store_s        mem_store;
  int                fail_count = 0;
  int                num_checks = 0;
  always #4 clk = ~clk;
  psd_datapath u_psd_datapath (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req(req), .mem_rdata(mem_rdata), .gpr_rdata(gpr_rdata), .done(done),
    .mem_store(mem_store), .mem_store_valid(mem_store_valid),
    .gpr_wdata(gpr_wdata), .gpr_wvalid(gpr_wvalid), .dst_value(dst_value));
  psd_far_model #(.GPR_VAL(GV)) u_psd_far_model (.clk(clk),
    .pre_valid(pre_valid), .pre_data(pre_data), .st_valid(mem_store_valid),
    .st(mem_store), .mem_rdata(mem_rdata), .gpr_rdata(gpr_rdata));
  // Compare one value
  task automatic chk(string n, logic [DATA_W-1:0] e, logic [DATA_W-1:0] g);
    num_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  // One request, answer sampled in the following cycle
  task automatic issue(psd_op_e o, psd_fmt_e f, psd_arith_e a, psd_acc_e c,
                       psd_src_e s, logic tm, logic [2:0] d, logic [2:0] r);
    @(posedge clk);
    #1 req = '{o, f, a, c, s, tm, d, r};
    req_valid = 1'b1;
    @(posedge clk);
    #1 req_valid = 1'b0;
    chk("done", 64'h1, {63'h0, done});
  endtask
  task automatic preload(logic [DATA_W-1:0] v);
    @(posedge clk);
    #1 pre_data = v;
    pre_valid = 1'b1;
    @(posedge clk);
    #1 pre_valid = 1'b0;
  endtask
  task automatic ld(logic [2:0] d, psd_acc_e c);
    issue(PSD_OP_MOVE, PSD_FMT_QWORD, PSD_ARITH_WRAP, c, PSD_SRC_MEM, 0, d, 0);
  endtask
  task automatic lane_op(psd_op_e o, psd_fmt_e f, psd_arith_e a,
                         logic [DATA_W-1:0] x, logic [DATA_W-1:0] y,
                         logic [DATA_W-1:0] e);
    preload(x);
    ld(1, PSD_ACC_FULL);
    chk("load", x, dst_value);
    preload(y);
    ld(2, PSD_ACC_FULL);
    issue(o, f, a, PSD_ACC_FULL, PSD_SRC_REG, 0, 1, 2);
    chk("lanes", e, dst_value);
  endtask
  // Lane splits, signedness, saturation, wraparound, compares and logic
  task automatic t_lanes;
    lane_op(PSD_OP_ADD, PSD_FMT_BYTE, PSD_ARITH_SSAT, BX, BY,
      64'h0000_807f_0002_807f);
    lane_op(PSD_OP_ADD, PSD_FMT_BYTE, PSD_ARITH_WRAP, BX, BY,
      64'h0000_8080_0002_7f80);
    lane_op(PSD_OP_ADD, PSD_FMT_BYTE, PSD_ARITH_USAT, BX, BY,
      64'hff00_ff80_ff02_ff80);
    lane_op(PSD_OP_SUB, PSD_FMT_BYTE, PSD_ARITH_USAT, BX, BY,
      64'h0000_0000_fe00_007e);
    lane_op(PSD_OP_CMPEQ, PSD_FMT_BYTE, PSD_ARITH_WRAP, BX, BY,
      64'h00ff_ffff_00ff_0000);
    lane_op(PSD_OP_ADD, PSD_FMT_WORD, PSD_ARITH_WRAP, '1,
      64'h0000_0001_0000_0001, 64'hffff_0000_ffff_0000);
    lane_op(PSD_OP_SUB, PSD_FMT_WORD, PSD_ARITH_SSAT,
      64'h8000_7fff_0005_0003, 64'h0001_ffff_0007_0001,
      64'h8000_7fff_fffe_0002);
    lane_op(PSD_OP_ADD, PSD_FMT_DWORD, PSD_ARITH_WRAP, '1,
      64'h0000_0001_0000_0001, 64'h0);
    lane_op(PSD_OP_CMPGT, PSD_FMT_DWORD, PSD_ARITH_SSAT,
      64'h8000_0000_0000_0002, 64'h0000_0001_ffff_ffff,
      64'h0000_0000_ffff_ffff);
    lane_op(PSD_OP_AND, PSD_FMT_QWORD, PSD_ARITH_WRAP, LX, LY,
      64'h0f0f_0000_0f00_f000);
    lane_op(PSD_OP_ANDN, PSD_FMT_QWORD, PSD_ARITH_WRAP, LX, LY,
      64'h0000_0f0f_00f0_0f00);
    lane_op(PSD_OP_OR, PSD_FMT_QWORD, PSD_ARITH_WRAP, LX, LY,
      64'hffff_0f0f_fff0_fff0);
    lane_op(PSD_OP_XOR, PSD_FMT_QWORD, PSD_ARITH_WRAP, LX, LY,
      64'hf0f0_0f0f_f0f0_0ff0);
  endtask
  // Half and full stores, then read back through memory
  task automatic t_store;
    preload(X);
    ld(3, PSD_ACC_FULL);
    preload(Y);
    issue(PSD_OP_MOVE, PSD_FMT_QWORD, PSD_ARITH_WRAP, PSD_ACC_HALF,
          PSD_SRC_REG, 1, 0, 3);
    chk("half en", 64'h0f, {56'h0, mem_store.byte_en});
    chk("store valid", 64'h1, {63'h0, mem_store_valid});
    ld(4, PSD_ACC_FULL);
    chk("merge", {Y[63:32], X[31:0]}, dst_value);
    issue(PSD_OP_MOVE, PSD_FMT_QWORD, PSD_ARITH_WRAP, PSD_ACC_FULL,
          PSD_SRC_REG, 1, 0, 3);
    chk("full data", X, mem_store.data);
    ld(5, PSD_ACC_HALF);
    chk("half load", {32'h0, X[31:0]}, dst_value);
  endtask
  // Moves between packed and integer registers
  task automatic t_gpr;
    issue(PSD_OP_MOVE, PSD_FMT_QWORD, PSD_ARITH_USAT, PSD_ACC_HALF,
          PSD_SRC_GPR, 0, 3, 3);
    chk("gpr out", {31'h0, 1'b1, X[31:0]},
        {31'h0, gpr_wvalid, gpr_wdata});
    issue(PSD_OP_MOVE, PSD_FMT_QWORD, PSD_ARITH_WRAP, PSD_ACC_HALF,
          PSD_SRC_GPR, 0, 6, 0);
    chk("gpr in", {32'h0, GV}, dst_value);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    t_lanes();
    t_store();
    t_gpr();
    wrap_up();
  end
endmodule
`default_nettype wire
